// ===== ucfm_pkg.sv
package ucfm_pkg;
  // clock and suspend timing
  localparam int CLK_HZ = 50_000_000;
  localparam int SUSP_IDLE_MS = 3;
  localparam int SUSP_LIMIT_MS = 7;
  localparam int SUSP_IDLE_CYC = CLK_HZ / 1000 * SUSP_IDLE_MS;
  localparam int SUSP_LIMIT_CYC = CLK_HZ / 1000 * SUSP_LIMIT_MS;
  // function map: hub plus five downstream functions
  localparam int NUM_DS_FUNC = 5;
  localparam int NUM_FUNC = NUM_DS_FUNC + 1;
  localparam logic [2:0] FN_HUB = 3'h0;
  localparam logic [2:0] FN_ETH = 3'h1;
  localparam logic [2:0] FN_UA = 3'h2;
  localparam logic [2:0] FN_UB = 3'h3;
  localparam logic [2:0] FN_I2C = 3'h4;
  localparam logic [2:0] FN_GPIO = 3'h5;
  localparam logic [2:0] FN_LAST = 3'h5;
  // power reporting
  localparam logic [8:0] HUB_MAX_MA = 9'h0FA;
  localparam logic [8:0] FUNC_MAX_MA = 9'h000;
  // endpoint kinds
  localparam logic [3:0] EP_CTRL = 4'h1;
  localparam logic [3:0] EP_INT_IN = 4'h2;
  localparam logic [3:0] EP_BULK = 4'h4;
  localparam logic [3:0] EP_INT_OUT = 4'h8;
  // serial string varying character
  localparam logic [7:0] SER_BASE = 8'h30;
  // class requests
  localparam logic [7:0] REQ_SET_LINE = 8'h20;
  localparam logic [7:0] REQ_GET_LINE = 8'h21;
  localparam logic [7:0] REQ_SET_CTRL = 8'h22;
  localparam logic [7:0] REQ_BREAK = 8'h23;
  // uart register defaults
  localparam logic [11:0] FLOW_HW = 12'h001;
  localparam logic [11:0] MODE_RTS_CTS = 12'h001;
  localparam logic [11:0] DIR_CLASS = 12'h008;
  localparam logic [11:0] MASK_CLASS = 12'h030;
  localparam logic [11:0] REG_ZERO = 12'h000;
  localparam logic [31:0] BAUD_DEF = 32'h0000_2580;
  localparam logic [7:0] BITS_DEF = 8'h08;
  // ethernet
  localparam logic [31:0] CRC_POLY = 32'hEDB8_8320;
  localparam logic [31:0] CRC_INIT = 32'hFFFF_FFFF;
  localparam logic [31:0] CRC_RESIDUE = 32'hDEBB_20E3;
  localparam logic [2:0] MAC_BYTES = 3'h6;

  typedef struct packed {
    logic [15:0] vid;
    logic [15:0] pid;
    logic [7:0] serial_ch;
    logic self_pwr;
    logic [8:0] max_ma;
    logic [3:0] ep_mask;
  } ucfm_desc_s;

  typedef struct packed {
    logic id_ovr;
    logic [15:0] vid;
    logic [15:0] pid;
    logic ser_ovr;
    logic [7:0] serial_ch;
    logic pwr_ovr;
    logic hub_self;
    logic [8:0] hub_ma;
    logic reg_ovr;
    logic [47:0] regs;
  } ucfm_otp_s;

  typedef struct packed {
    logic [11:0] flow;
    logic [11:0] mode;
    logic [11:0] dir;
    logic [11:0] mask;
  } ucfm_gpio_s;

  typedef struct packed {
    logic [31:0] baud;
    logic [7:0] stop;
    logic [7:0] parity;
    logic [7:0] bits;
  } ucfm_line_s;
endpackage

// ===== ucfm_crc32.sv
`timescale 1ns/1ps
module ucfm_crc32 #(
  parameter logic [31:0] POLY = ucfm_pkg::CRC_POLY
) (
  // clock and reset
  input wire logic clk,
  input wire logic srst,
  // byte stream
  input wire logic start,
  input wire logic valid,
  input wire logic [7:0] data,
  // running remainder
  output logic [31:0] crc
);
  function automatic logic [31:0] crc_byte(input logic [31:0] c, input logic [7:0] d);
    logic [31:0] r;
    r = c ^ {24'h00_0000, d};
    for (int i = 0; i < 8; i++) begin
      r = r[0] ? ((r >> 1) ^ POLY) : (r >> 1);
    end
    return r;
  endfunction

  // start restarts from the seed, so a new frame never inherits old bytes
  always_ff @(posedge clk) begin
    if (srst || (start && !valid)) begin
      crc <= ucfm_pkg::CRC_INIT;
    end else if (valid) begin
      crc <= crc_byte(start ? ucfm_pkg::CRC_INIT : crc, data);
    end
  end
endmodule

// ===== ucfm_core.sv
`timescale 1ns/1ps
//
// Contract
// - compound device: hub plus five downstream functions, fixed map
// - upstream full or high speed; functions behind hub always high speed
// - one vendor id for all; own product and serial per function
// - serial strings differ by one character 0 to 5
// - ids and strings from one-time memory when overridden, else built-in
// - hub reports bus powered 250 mA; other functions self powered
// - bus powered: phy off in suspend; self powered hub may keep it
// - one configuration per function with the fixed endpoint sets
// - suspend begins after 3 ms without upstream activity
// - within 7 ms of suspend, power down to the suspend budget
// - falling edge on an input ring wake pin while suspended requests wakeup
// - wake pins are anded; a low pin blocks resume
// - ring pins wake by default; rx pins only if input and enabled
// - class driver: flow control and pin mode both 0x001
// - class driver: direction 0x008, terminal ready pins outputs
// - class driver: interrupt mask 0x030
// - vendor driver: all gpio inputs, later reprogrammable
// - vendor flag set stops class defaults being forced
// - four class requests: line coding set and get, control, break
// - ethernet crc generate and check, unicast and multicast filter
// - ones complement checksum offload for ip headers and payloads
module ucfm_core #(
  parameter int IDLE_CYC = ucfm_pkg::SUSP_IDLE_CYC,
  parameter int LIMIT_CYC = ucfm_pkg::SUSP_LIMIT_CYC,
  // arbitrary identity values
  parameter logic [15:0] DEF_VID = 16'hA5A5,
  parameter logic [15:0] DEF_PID = 16'h5A00
) (
  // clock and reset
  input wire logic clk,
  input wire logic srst,
  // upstream link status
  input wire logic bus_activity,
  input wire logic link_high_speed,
  input wire logic host_wake_en,
  // wake pins and their configuration
  input wire logic ring_wake_pin_a,
  input wire logic ring_wake_pin_b,
  input wire logic rx_wake_pin_a,
  input wire logic rx_wake_pin_b,
  input wire logic [3:0] wake_pin_is_input,
  input wire logic [1:0] rx_wake_enable,
  // descriptor query
  input wire logic desc_req,
  input wire logic [2:0] desc_fn,
  input wire ucfm_pkg::ucfm_otp_s otp,
  output ucfm_pkg::ucfm_desc_s desc,
  output logic desc_valid,
  // driver and class requests
  input wire logic class_attach,
  input wire logic vendor_flag_set,
  input wire logic reg_write,
  input wire ucfm_pkg::ucfm_gpio_s reg_wdata,
  input wire logic class_req,
  input wire logic [7:0] class_code,
  input wire logic [15:0] class_value,
  input wire ucfm_pkg::ucfm_line_s class_line,
  output ucfm_pkg::ucfm_gpio_s gpio_cfg,
  output ucfm_pkg::ucfm_line_s line_cfg,
  output logic [1:0] ctrl_lines,
  output logic break_active,
  output logic vendor_mode,
  // ethernet frame streams
  input wire logic [47:0] mac_addr,
  input wire logic mcast_en,
  input wire logic tx_valid,
  input wire logic tx_first,
  input wire logic tx_last,
  input wire logic [7:0] tx_data,
  input wire logic rx_valid,
  input wire logic rx_first,
  input wire logic rx_last,
  input wire logic [7:0] rx_data,
  output logic [31:0] tx_fcs,
  output logic tx_fcs_valid,
  output logic rx_done,
  output logic rx_fcs_ok,
  output logic rx_accept,
  // checksum offload
  input wire logic csum_clear,
  input wire logic csum_valid,
  input wire logic [15:0] csum_word,
  output logic [15:0] csum_result,
  // power and status
  output logic suspended,
  output logic power_down_done,
  output logic phy_power_down,
  output logic resume_req,
  output logic func_high_speed,
  output logic upstream_high_speed
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (srst);

  function automatic logic [3:0] ep_map(input logic [2:0] fn);
    case (fn)
      ucfm_pkg::FN_HUB: ep_map = ucfm_pkg::EP_CTRL | ucfm_pkg::EP_INT_IN;
      ucfm_pkg::FN_ETH, ucfm_pkg::FN_UA, ucfm_pkg::FN_UB:
        ep_map = ucfm_pkg::EP_CTRL | ucfm_pkg::EP_INT_IN | ucfm_pkg::EP_BULK;
      ucfm_pkg::FN_I2C, ucfm_pkg::FN_GPIO:
        ep_map = ucfm_pkg::EP_CTRL | ucfm_pkg::EP_INT_IN | ucfm_pkg::EP_INT_OUT;
      default: ep_map = 4'h0;
    endcase
  endfunction

  function automatic logic [15:0] ocsum_add(input logic [15:0] a, input logic [15:0] b);
    logic [16:0] s;
    s = {1'b0, a} + {1'b0, b};
    return s[15:0] + {15'h0000, s[16]};
  endfunction

  // pin synchronisers
  logic [4:0] sync1_q;
  logic [4:0] sync2_q;
  always_ff @(posedge clk) begin
    if (srst) begin
      sync1_q <= 5'h1F;
      sync2_q <= 5'h1F;
    end else begin
      sync1_q <= {bus_activity, rx_wake_pin_b, rx_wake_pin_a, ring_wake_pin_b, ring_wake_pin_a};
      sync2_q <= sync1_q;
    end
  end
  logic act_s;
  assign act_s = sync2_q[4];

  always_ff @(posedge clk) begin
    if (srst) begin
      func_high_speed <= 1'b1;
      upstream_high_speed <= 1'b0;
    end else begin
      func_high_speed <= 1'b1;
      upstream_high_speed <= link_high_speed;
    end
  end

  logic [$clog2(IDLE_CYC+1)-1:0] idle_q;
  logic susp_start;
  assign susp_start = !suspended && !act_s && (idle_q == ($bits(idle_q))'(IDLE_CYC - 1));
  always_ff @(posedge clk) begin
    if (srst || act_s) begin
      idle_q <= '0;
    end else if (!suspended) begin
      idle_q <= idle_q + 1'b1;
    end
  end
  always_ff @(posedge clk) begin
    if (srst || act_s) begin
      suspended <= 1'b0;
    end else if (susp_start) begin
      suspended <= 1'b1;
    end
  end

  // power down inside the limit; done one cycle after entry
  logic [$clog2(LIMIT_CYC+1)-1:0] lim_q;
  always_ff @(posedge clk) begin
    if (srst || !suspended) begin
      lim_q <= '0;
      power_down_done <= 1'b0;
    end else begin
      power_down_done <= 1'b1;
      if (lim_q != ($bits(lim_q))'(LIMIT_CYC)) begin
        lim_q <= lim_q + 1'b1;
      end
    end
  end

  // in suspend the phy stays on only when the hub reports self powered
  logic hub_self;
  assign hub_self = otp.pwr_ovr && otp.hub_self;
  always_ff @(posedge clk) begin
    if (srst) begin
      phy_power_down <= 1'b0;
    end else begin
      phy_power_down <= suspended && !hub_self;
    end
  end

  // anded wake level; unused or disabled pins read high
  logic [3:0] wake_use;
  logic wake_and;
  logic wake_prev_q;
  assign wake_use = wake_pin_is_input & {rx_wake_enable, 2'b11};
  assign wake_and = &(sync2_q[3:0] | ~wake_use);
  always_ff @(posedge clk) begin
    if (srst) begin
      wake_prev_q <= 1'b1;
    end else begin
      wake_prev_q <= wake_and;
    end
  end

  // falling edge while suspended; gated by host enable
  always_ff @(posedge clk) begin
    if (srst) begin
      resume_req <= 1'b0;
    end else begin
      resume_req <= suspended && host_wake_en && wake_prev_q && !wake_and;
    end
  end

  ucfm_pkg::ucfm_desc_s desc_d;
  always_comb begin
    desc_d.vid = otp.id_ovr ? otp.vid : DEF_VID;
    desc_d.pid = otp.id_ovr ? otp.pid : (DEF_PID | {13'h0000, desc_fn});
    desc_d.serial_ch = otp.ser_ovr ? otp.serial_ch : (ucfm_pkg::SER_BASE | {5'h00, desc_fn});
    if (desc_fn == ucfm_pkg::FN_HUB) begin
      desc_d.self_pwr = hub_self;
      desc_d.max_ma = otp.pwr_ovr ? otp.hub_ma : ucfm_pkg::HUB_MAX_MA;
    end else begin
      desc_d.self_pwr = 1'b1;
      desc_d.max_ma = ucfm_pkg::FUNC_MAX_MA;
    end
    desc_d.ep_mask = ep_map(desc_fn);
  end
  always_ff @(posedge clk) begin
    if (srst) begin
      desc <= '0;
      desc_valid <= 1'b0;
    end else begin
      desc_valid <= desc_req && (desc_fn <= ucfm_pkg::FN_LAST);
      if (desc_req && (desc_fn <= ucfm_pkg::FN_LAST)) begin
        desc <= desc_d;
      end
    end
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      vendor_mode <= 1'b0;
    end else if (vendor_flag_set) begin
      vendor_mode <= 1'b1;
    end
  end

  // class defaults, overridable from one-time memory
  ucfm_pkg::ucfm_gpio_s class_def;
  always_comb begin
    if (otp.reg_ovr) begin
      class_def = otp.regs;
    end else begin
      class_def.flow = ucfm_pkg::FLOW_HW;
      class_def.mode = ucfm_pkg::MODE_RTS_CTS;
      class_def.dir = ucfm_pkg::DIR_CLASS;
      class_def.mask = ucfm_pkg::MASK_CLASS;
    end
  end
  // vendor reset: all inputs; writes steer later
  always_ff @(posedge clk) begin
    if (srst) begin
      gpio_cfg <= {4{ucfm_pkg::REG_ZERO}};
    end else if (reg_write) begin
      gpio_cfg <= reg_wdata;
    end else if (class_attach && !vendor_mode && !vendor_flag_set) begin
      gpio_cfg <= class_def;
    end
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      line_cfg <= {ucfm_pkg::BAUD_DEF, 16'h0000, ucfm_pkg::BITS_DEF};
      ctrl_lines <= 2'h0;
      break_active <= 1'b0;
    end else if (class_req) begin
      case (class_code)
        ucfm_pkg::REQ_SET_LINE: line_cfg <= class_line;
        ucfm_pkg::REQ_SET_CTRL: ctrl_lines <= class_value[1:0];
        ucfm_pkg::REQ_BREAK: break_active <= class_value != 16'h0000;
        default: ;
      endcase
    end
  end

  logic [31:0] tx_crc;
  logic [31:0] rx_crc;
  ucfm_crc32 u_tx_crc (
    .clk(clk),
    .srst(srst),
    .start(tx_first),
    .valid(tx_valid),
    .data(tx_data),
    .crc(tx_crc)
  );
  ucfm_crc32 u_rx_crc (
    .clk(clk),
    .srst(srst),
    .start(rx_first),
    .valid(rx_valid),
    .data(rx_data),
    .crc(rx_crc)
  );
  logic tx_end_q;
  logic rx_end_q;
  always_ff @(posedge clk) begin
    if (srst) begin
      tx_end_q <= 1'b0;
      rx_end_q <= 1'b0;
    end else begin
      tx_end_q <= tx_valid && tx_last;
      rx_end_q <= rx_valid && rx_last;
    end
  end
  // fcs out and check, one cycle after the engine settles
  always_ff @(posedge clk) begin
    if (srst) begin
      tx_fcs <= '0;
      tx_fcs_valid <= 1'b0;
      rx_done <= 1'b0;
      rx_fcs_ok <= 1'b0;
    end else begin
      tx_fcs_valid <= tx_end_q;
      rx_done <= rx_end_q;
      if (tx_end_q) begin
        tx_fcs <= ~tx_crc;
      end
      if (rx_end_q) begin
        rx_fcs_ok <= rx_crc == ucfm_pkg::CRC_RESIDUE;
      end
    end
  end

  // address filter over the first six bytes
  logic [2:0] rx_idx_q;
  logic uni_q;
  logic mc_q;
  logic [2:0] idx_now;
  logic [7:0] mac_byte;
  assign idx_now = rx_first ? 3'h0 : rx_idx_q;
  assign mac_byte = mac_addr[8'(47 - 8 * idx_now) -: 8];
  always_ff @(posedge clk) begin
    if (srst) begin
      rx_idx_q <= 3'h0;
      uni_q <= 1'b0;
      mc_q <= 1'b0;
    end else if (rx_valid) begin
      if (idx_now < ucfm_pkg::MAC_BYTES) begin
        rx_idx_q <= idx_now + 3'h1;
        uni_q <= (rx_first || uni_q) && (rx_data == mac_byte);
      end
      if (rx_first) begin
        mc_q <= rx_data[0];
      end
    end
  end
  always_ff @(posedge clk) begin
    if (srst) begin
      rx_accept <= 1'b0;
    end else if (rx_end_q) begin
      rx_accept <= uni_q || (mc_q && mcast_en);
    end
  end

  // ones complement accumulator shared by header and payload sums
  logic [15:0] csum_q;
  always_ff @(posedge clk) begin
    if (srst || csum_clear) begin
      csum_q <= 16'h0000;
    end else if (csum_valid) begin
      csum_q <= ocsum_add(csum_q, csum_word);
    end
  end
  always_ff @(posedge clk) begin
    if (srst) begin
      csum_result <= 16'hFFFF;
    end else begin
      csum_result <= ~csum_q;
    end
  end

  // checks
  a_susp_entry: assert property (susp_start |=> suspended)
    else $error("suspend not entered after idle");
  a_susp_idle: assert property ($rose(suspended) |-> $past(idle_q) == ($bits(idle_q))'(IDLE_CYC - 1))
    else $error("suspend entered early");
  a_pwr_limit: assert property ($rose(suspended) |-> ##[1:2]
    (power_down_done && lim_q < ($bits(lim_q))'(LIMIT_CYC)))
    else $error("power down too late");
  a_phy_bus_pwr: assert property (suspended && !hub_self |=> phy_power_down)
    else $error("phy left on in bus powered suspend");
  a_wake_gate: assert property (resume_req |-> $past(host_wake_en) && $past(suspended))
    else $error("resume without host enable");
  a_wake_and: assert property (resume_req |-> !$past(wake_and) && $past(wake_prev_q))
    else $error("resume without anded falling edge");
  a_wake_edge: assert property (suspended && host_wake_en && wake_prev_q && !wake_and |=> resume_req)
    else $error("wake edge lost");
  a_class_dflt: assert property (class_attach && !vendor_mode && !vendor_flag_set && !reg_write && !otp.reg_ovr
    |=> gpio_cfg.dir == ucfm_pkg::DIR_CLASS && gpio_cfg.mask == ucfm_pkg::MASK_CLASS)
    else $error("class defaults not applied");
  a_vendor_keep: assert property (vendor_mode && !reg_write |=> $stable(gpio_cfg))
    else $error("class defaults forced in vendor mode");
  a_func_speed: assert property (func_high_speed
    && ($past(srst) || upstream_high_speed == $past(link_high_speed)))
    else $error("function not high speed");
  a_hub_power: assert property (desc_valid && desc.ep_mask == (ucfm_pkg::EP_CTRL | ucfm_pkg::EP_INT_IN)
    && !$past(hub_self) |-> !desc.self_pwr
    && desc.max_ma == $past(otp.pwr_ovr ? otp.hub_ma : ucfm_pkg::HUB_MAX_MA))
    else $error("hub power wrong");
  c_suspend: cover property (suspended ##[1:4] power_down_done);
  c_resume: cover property (resume_req);
  c_rx_ok: cover property (rx_done && rx_fcs_ok && rx_accept);
  c_class: cover property (class_attach ##1 gpio_cfg.flow == ucfm_pkg::FLOW_HW);
endmodule

// ===== ucfm_host_model.sv
`timescale 1ns/1ps
module ucfm_host_model (
  // clock and reset
  input wire logic clk,
  input wire logic srst,
  // bench control
  input wire logic run,
  // upstream bus
  output logic bus_activity,
  input wire logic resume_req,
  output int resume_cnt
);
  logic [2:0] frame_q;

  // frame markers
  // a burst every eight cycles keeps the idle gap well short of the suspend count
  always_ff @(posedge clk) begin
    if (srst || !run) begin
      frame_q <= 3'h0;
      bus_activity <= 1'h0;
    end else begin
      frame_q <= frame_q + 3'h1;
      bus_activity <= (frame_q == 3'h0);
    end
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      resume_cnt <= 0;
    end else if (resume_req === 1'h1) begin
      resume_cnt <= resume_cnt + 1;
    end
  end
endmodule

// ===== usb_compound_function_manager_bench.sv
`timescale 1ns/1ps
module usb_compound_function_manager_bench;
  // arbitrary identity values
  localparam logic [15:0] VID = 16'h1234;
  localparam logic [15:0] PID = 16'h6700;
  localparam int IDLE = 20;
  logic clk, srst, host_run, host_wake_en, link_high_speed, bus_activity;
  logic [3:0] wk, wake_pin_is_input;
  logic [1:0] rx_wake_enable, ctrl_lines;
  logic desc_req, desc_valid, class_attach, vendor_flag_set, reg_write, class_req;
  logic [2:0] desc_fn;
  ucfm_pkg::ucfm_otp_s otp;
  ucfm_pkg::ucfm_desc_s desc;
  ucfm_pkg::ucfm_gpio_s reg_wdata, gpio_cfg;
  ucfm_pkg::ucfm_line_s class_line, line_cfg;
  logic [7:0] class_code, tx_data, rx_data;
  logic [15:0] class_value, csum_word, csum_result;
  logic break_active, vendor_mode, mcast_en, tx_valid, tx_first, tx_last;
  logic rx_valid, rx_first, rx_last, tx_fcs_valid, rx_done, rx_fcs_ok, rx_accept;
  logic [47:0] mac_addr;
  logic [31:0] tx_fcs;
  logic csum_clear, csum_valid, suspended, power_down_done, phy_power_down;
  logic resume_req, func_high_speed, upstream_high_speed;
  int resume_cnt, err_count, cmp_count;
  logic [7:0] frm [0:11];

  ucfm_core #(.IDLE_CYC(IDLE), .LIMIT_CYC(40), .DEF_VID(VID), .DEF_PID(PID)) dut_u (
    .clk, .srst, .bus_activity, .link_high_speed, .host_wake_en,
    .ring_wake_pin_a(wk[0]), .ring_wake_pin_b(wk[1]), .rx_wake_pin_a(wk[2]), .rx_wake_pin_b(wk[3]),
    .wake_pin_is_input, .rx_wake_enable, .desc_req, .desc_fn, .otp, .desc, .desc_valid,
    .class_attach, .vendor_flag_set, .reg_write, .reg_wdata, .class_req, .class_code,
    .class_value, .class_line, .gpio_cfg, .line_cfg, .ctrl_lines, .break_active, .vendor_mode,
    .mac_addr, .mcast_en, .tx_valid, .tx_first, .tx_last, .tx_data, .rx_valid, .rx_first,
    .rx_last, .rx_data, .tx_fcs, .tx_fcs_valid, .rx_done, .rx_fcs_ok, .rx_accept, .csum_clear,
    .csum_valid, .csum_word, .csum_result, .suspended, .power_down_done, .phy_power_down,
    .resume_req, .func_high_speed, .upstream_high_speed
  );

  ucfm_host_model host_u (.clk, .srst, .run(host_run), .bus_activity, .resume_req, .resume_cnt);

  initial begin
    clk = 1'h0;
    forever #10 clk = ~clk;
  end

  task automatic chk(input logic [63:0] g, input logic [63:0] e, input string m);
    cmp_count++;
    if (g !== e) begin
      err_count++;
      $display("wrong value at %0t: %s", $time, m);
    end
  endtask

  task automatic report_and_stop();
    $display("comparisons %0d mismatches %0d", cmp_count, err_count);
    if (err_count == 0 && cmp_count > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask

  // k: 0 attach, 1 vendor flag, 2 reg write, 3 sum clear, 4 sum word
  task automatic pulse(input int k);
    @(posedge clk);
    class_attach <= (k == 0);
    vendor_flag_set <= (k == 1);
    reg_write <= (k == 2);
    csum_clear <= (k == 3);
    csum_valid <= (k == 4);
    @(posedge clk);
    {class_attach, vendor_flag_set, reg_write, csum_clear, csum_valid} <= 5'h00;
    repeat (3) @(posedge clk);
    #1;
  endtask

  task automatic t_reset();
    chk(gpio_cfg, 48'h0, "gpio after reset");
    chk(line_cfg, {ucfm_pkg::BAUD_DEF, 16'h0000, ucfm_pkg::BITS_DEF}, "line after reset");
    chk(upstream_high_speed, 1'h0, "full speed link");
    @(posedge clk);
    link_high_speed <= 1'h1;
    repeat (3) @(posedge clk);
    #1;
    chk(upstream_high_speed, 1'h1, "high speed link");
    chk(func_high_speed, 1'h1, "functions high speed");
    $display("test reset finished");
  endtask

  task automatic get_desc(input logic [2:0] fn, output logic got);
    @(posedge clk);
    desc_req <= 1'h1;
    desc_fn <= fn;
    @(posedge clk);
    desc_req <= 1'h0;
    got = 1'h0;
    for (int i = 0; i < 3; i++) begin
      #1;
      if (desc_valid === 1'h1) got = 1'h1;
      @(posedge clk);
    end
  endtask

  task automatic t_desc();
    logic got;
    for (int f = 0; f < 7; f++) begin
      get_desc(f[2:0], got);
      chk(got, f < 6, "descriptor answer");
      if (f < 6) begin
        chk(desc.vid, VID, "vendor id");
        chk(desc.pid, PID | f[15:0], "product id");
        chk(desc.serial_ch, 8'h30 | f[7:0], "serial char");
        chk(desc.self_pwr, f != 0, "power mode");
        chk(desc.max_ma, (f == 0) ? 9'h0FA : 9'h000, "max power");
        chk(desc.ep_mask, (f == 0) ? 4'h3 : (f < 4) ? 4'h7 : 4'hB, "endpoints");
      end
    end
    otp.id_ovr <= 1'h1;
    otp.ser_ovr <= 1'h1;
    {otp.pwr_ovr, otp.hub_self} <= 2'h3;
    get_desc(3'h0, got);
    chk(desc.vid, 16'h3C3C, "vendor override");
    chk(desc.pid, 16'h4D4D, "product override");
    chk(desc.serial_ch, 8'h37, "serial override");
    chk({desc.self_pwr, desc.max_ma}, {1'h1, 9'h064}, "self powered hub");
    otp.id_ovr <= 1'h0;
    otp.ser_ovr <= 1'h0;
    {otp.pwr_ovr, otp.hub_self} <= 2'h0;
    $display("test descriptors finished");
  endtask

  task automatic t_regs();
    pulse(0);
    chk(gpio_cfg, {12'h001, 12'h001, 12'h008, 12'h030}, "class defaults");
    pulse(1);
    chk(vendor_mode, 1'h1, "vendor mode");
    pulse(2);
    chk(gpio_cfg, 48'h0, "vendor inputs");
    pulse(0);
    chk(gpio_cfg, 48'h0, "class not forced");
    $display("test registers finished");
  endtask

  task automatic creq(input logic [7:0] c, input logic [15:0] v);
    @(posedge clk);
    class_req <= 1'h1;
    class_code <= c;
    class_value <= v;
    @(posedge clk);
    class_req <= 1'h0;
    repeat (2) @(posedge clk);
    #1;
  endtask

  task automatic t_class();
    creq(ucfm_pkg::REQ_SET_LINE, 16'h0000);
    chk(line_cfg, class_line, "line coding");
    creq(ucfm_pkg::REQ_SET_CTRL, 16'h0003);
    chk(ctrl_lines, 2'h3, "control lines");
    creq(ucfm_pkg::REQ_BREAK, 16'h0001);
    chk(break_active, 1'h1, "break on");
    creq(ucfm_pkg::REQ_GET_LINE, 16'h0000);
    chk({line_cfg, break_active}, {class_line, 1'h1}, "get is harmless");
    creq(ucfm_pkg::REQ_BREAK, 16'h0000);
    chk(break_active, 1'h0, "break off");
    $display("test class requests finished");
  endtask

  function automatic logic [31:0] crc_of(input int n);
    logic [31:0] c;
    c = 32'hFFFF_FFFF;
    for (int i = 0; i < n; i++) begin
      c ^= {24'h0, frm[i]};
      for (int b = 0; b < 8; b++) c = c[0] ? (c >> 1) ^ 32'hEDB8_8320 : c >> 1;
    end
    return ~c;
  endfunction

  task automatic frame(input logic rx, input int n, output logic seen);
    seen = 1'h0;
    for (int i = 0; i < n; i++) begin
      @(posedge clk);
      tx_valid <= !rx;
      rx_valid <= rx;
      {tx_first, rx_first} <= {2{i == 0}};
      {tx_last, rx_last} <= {2{i == n - 1}};
      tx_data <= frm[i];
      rx_data <= frm[i];
    end
    @(posedge clk);
    tx_valid <= 1'h0;
    rx_valid <= 1'h0;
    for (int i = 0; i < 5; i++) begin
      #1;
      if ((rx ? rx_done : tx_fcs_valid) === 1'h1) seen = 1'h1;
      @(posedge clk);
    end
  endtask

  task automatic t_eth();
    logic [31:0] fcs;
    logic seen;
    for (int i = 0; i < 6; i++) frm[i] = mac_addr[47 - 8 * i -: 8];
    frm[6] = 8'h08;
    frm[7] = 8'h00;
    fcs = crc_of(8);
    for (int i = 0; i < 4; i++) frm[8 + i] = fcs[8 * i +: 8];
    frame(1'h0, 8, seen);
    chk({seen, tx_fcs}, {1'h1, fcs}, "transmit fcs");
    frame(1'h1, 12, seen);
    chk({seen, rx_fcs_ok, rx_accept}, 3'h7, "good frame");
    frm[7] = 8'h01;
    frame(1'h1, 12, seen);
    chk({seen, rx_fcs_ok}, 2'h2, "bad frame");
    frm[0] = 8'h03;
    frame(1'h1, 12, seen);
    chk({seen, rx_accept}, 2'h2, "foreign address dropped");
    mcast_en <= 1'h1;
    frame(1'h1, 12, seen);
    chk({seen, rx_accept}, 2'h3, "multicast taken");
    $display("test ethernet finished");
  endtask

  task automatic t_csum();
    @(posedge clk);
    csum_word <= 16'hFFFF;
    pulse(4);
    @(posedge clk);
    csum_word <= 16'h0002;
    pulse(4);
    chk(csum_result, 16'hFFFD, "carry folded");
    pulse(3);
    chk(csum_result, 16'hFFFF, "cleared sum");
    $display("test checksum finished");
  endtask

  task automatic wake_step(input logic [3:0] lvl, input int exp);
    int c0;
    c0 = resume_cnt;
    @(posedge clk);
    wk <= lvl;
    repeat (8) @(posedge clk);
    #1;
    chk(resume_cnt - c0, exp, "resume count");
  endtask

  task automatic t_susp();
    int n;
    chk(suspended, 1'h0, "busy bus awake");
    @(posedge clk);
    while (bus_activity !== 1'h1) @(posedge clk);
    host_run <= 1'h0;
    repeat (2) @(posedge clk);
    for (n = 0; n < 60 && suspended !== 1'h1; n++) begin
      @(posedge clk);
      #1;
    end
    chk(n >= IDLE - 2 && n <= IDLE + 6, 1'h1, "idle span");
    repeat (2) @(posedge clk);
    #1;
    chk(power_down_done, 1'h1, "power down done");
    chk(phy_power_down, 1'h1, "phy off");
    @(posedge clk);
    {otp.pwr_ovr, otp.hub_self} <= 2'h3;
    repeat (2) @(posedge clk);
    #1;
    chk(phy_power_down, 1'h0, "phy kept for self powered hub");
    @(posedge clk);
    {otp.pwr_ovr, otp.hub_self} <= 2'h0;
    wake_step(4'hE, 1);
    wake_step(4'hF, 0);
    wake_step(4'hD, 1);
    wake_step(4'hC, 0);
    wake_step(4'hF, 0);
    wake_step(4'hB, 0);
    wake_step(4'hF, 0);
    @(posedge clk);
    wake_pin_is_input <= 4'hF;
    rx_wake_enable <= 2'h1;
    wake_step(4'hB, 1);
    wake_step(4'hF, 0);
    @(posedge clk);
    host_wake_en <= 1'h0;
    wake_step(4'hE, 0);
    wake_step(4'hF, 0);
    @(posedge clk);
    host_run <= 1'h1;
    repeat (8) @(posedge clk);
    #1;
    chk({suspended, phy_power_down}, 2'h0, "awake again");
    $display("test suspend finished");
  endtask

  initial begin
    srst = 1'h1;
    host_run = 1'h1;
    host_wake_en = 1'h1;
    link_high_speed = 1'h0;
    wk = 4'hF;
    wake_pin_is_input = 4'h3;
    rx_wake_enable = 2'h0;
    {desc_req, class_attach, vendor_flag_set, reg_write, class_req} = 5'h00;
    desc_fn = 3'h0;
    otp = '0;
    otp.vid = 16'h3C3C;
    otp.pid = 16'h4D4D;
    otp.serial_ch = 8'h37;
    otp.hub_ma = 9'h064;
    reg_wdata = '0;
    class_line = '{32'h0001_C200, 8'h01, 8'h02, 8'h07};
    class_code = 8'h00;
    class_value = 16'h0000;
    mac_addr = 48'h02A1_B2C3_D4E5;
    mcast_en = 1'h0;
    {tx_valid, tx_first, tx_last, rx_valid, rx_first, rx_last} = 6'h00;
    tx_data = 8'h00;
    rx_data = 8'h00;
    {csum_clear, csum_valid} = 2'h0;
    csum_word = 16'h0000;
    err_count = 0;
    cmp_count = 0;
    repeat (4) @(posedge clk);
    srst <= 1'h0;
    repeat (2) @(posedge clk);
    #1;
    t_reset();
    t_desc();
    t_regs();
    t_class();
    t_eth();
    t_csum();
    t_susp();
    report_and_stop();
  end

  // run needs well under two thousand cycles
  initial begin
    repeat (20000) @(posedge clk);
    err_count++;
    $display("wrong value at %0t: watchdog expired", $time);
    report_and_stop();
  end
endmodule
